// ---- inc/lbus_pkg.sv ----
/*
  Shared constants of the local bus cycle engine: register map, field
  positions, reset values, cycle codes and bus states.
  Assumes a single 20 MHz clock domain.
*/
package lbus_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] ADDR_OFF = 8'h04;
  localparam logic [7:0] WDATA_OFF = 8'h08;
  localparam logic [7:0] CFG_OFF = 8'h0c;
  localparam logic [7:0] RDATA_OFF = 8'h10;
  localparam logic [7:0] STAT_OFF = 8'h14;
  // CTRL fields: cycle code [2:0], byte flag, first-acknowledge flag
  localparam int CTRL_BYTE_BIT = 3;
  localparam int CTRL_FIRST_BIT = 4;
  // CFG fields: segment code [1:0], interrupt enable, seventh status bit
  localparam int CFG_IRQ_BIT = 2;
  localparam int CFG_SEVEN_BIT = 3;
  localparam logic [3:0] CFG_RST = 4'h2;
  // STAT fields: state [2:0], hold seen, busy
  localparam int STAT_HOLD_BIT = 3;
  localparam int STAT_BUSY_BIT = 4;
  // Cycle codes
  localparam logic [2:0] CYC_MEM_RD = 3'h0;
  localparam logic [2:0] CYC_MEM_WR = 3'h1;
  localparam logic [2:0] CYC_IO_RD = 3'h2;
  localparam logic [2:0] CYC_IO_WR = 3'h3;
  localparam logic [2:0] CYC_INTA = 3'h4;
  // Segment codes
  localparam logic [1:0] SEG_ALT = 2'h0;
  localparam logic [1:0] SEG_STACK = 2'h1;
  localparam logic [1:0] SEG_CODE = 2'h2;
  localparam logic [1:0] SEG_DATA = 2'h3;
  // Clock cycles per bus state
  localparam int TSTATE_CYCLES = 4;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDRESS, ST_T2, ST_T3, ST_WAIT, ST_T4} bstate_t;
endpackage

// ---- rtl/lbus_engine.sv ----
/*
  Local bus cycle engine: software posts a cycle over AHB-Lite, the engine
  runs the address, data, wait and end states on the multiplexed pins.
  Assumes pin inputs are asynchronous and bidirectional pins are resolved
  outside from the enables.
*/
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module lbus_engine #(
  parameter int TDIV = lbus_pkg::TSTATE_CYCLES
) (
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic hreadyout, // never stalls
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  input wire logic [15:0] addr_data_lines_i, // shared lines in
  output logic [15:0] addr_data_lines_o, // shared lines out
  output logic addr_data_lines_oe, // shared lines drive
  output logic [3:0] upper_addr_status_o, // top is line_top, bit 0 line_low
  output logic upper_addr_status_oe, // upper lines drive
  output logic high_byte_enable_n_o, // high byte enable / status seven
  output logic high_byte_enable_oe, // its drive
  output logic read_n_o, // read strobe
  output logic read_n_oe, // its drive
  output logic second_status_pin_o, // high for memory cycles
  input wire logic ready_i, // ready from device
  input wire logic hold_ack_i // hold acknowledged
);
  lbus_pkg::bstate_t state_r, state_nxt;
  logic [$clog2(TDIV)-1:0] cnt_r;
  logic ready_m, ready_s, hold_m, hold_s;
  logic [15:0] ad_m, ad_s;
  logic [2:0] cyc_r;
  logic byte_r, first_r, pend_r;
  logic [19:0] addr_r;
  logic [15:0] wdata_r, rdata_r;
  logic [3:0] cfg_r;
  logic irq_q_r;
  logic ph_wr_r;
  logic [7:0] ph_addr_r;

  // AHB-Lite decode
  wire addr_ph = hsel && htrans[1] && hready;
  wire wr_go = ph_wr_r;
  wire rd_go = addr_ph && !hwrite;
  wire busy = pend_r || (state_r != lbus_pkg::ST_IDLE);
  wire ctrl_wr = wr_go && (ph_addr_r == lbus_pkg::CTRL_OFF) && !busy && !hold_s;
  wire addr_wr = wr_go && (ph_addr_r == lbus_pkg::ADDR_OFF) && !busy;
  wire wdata_wr = wr_go && (ph_addr_r == lbus_pkg::WDATA_OFF) && !busy;
  wire cfg_wr = wr_go && (ph_addr_r == lbus_pkg::CFG_OFF);
  wire [7:0] stat_v = {3'h0, busy, hold_s, 3'(state_r)};
  wire [7:0] raddr = haddr[7:0];
  wire [31:0] rmux =
    (raddr == lbus_pkg::CTRL_OFF) ? {27'h0, first_r, byte_r, cyc_r} :
    (raddr == lbus_pkg::ADDR_OFF) ? {12'h0, addr_r} :
    (raddr == lbus_pkg::WDATA_OFF) ? {16'h0, wdata_r} :
    (raddr == lbus_pkg::CFG_OFF) ? {28'h0, cfg_r} :
    (raddr == lbus_pkg::RDATA_OFF) ? {16'h0, rdata_r} :
    (raddr == lbus_pkg::STAT_OFF) ? {24'h0, stat_v} : 32'h0;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_r <= 1'b0;
      ph_addr_r <= 8'h0;
      hrdata <= 32'h0;
    end else begin
      ph_wr_r <= addr_ph && hwrite;
      if (addr_ph)
        ph_addr_r <= haddr[7:0];
      if (rd_go)
        hrdata <= rmux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_r <= lbus_pkg::CYC_MEM_RD;
      byte_r <= 1'b0;
      first_r <= 1'b0;
      addr_r <= 20'h0;
      wdata_r <= 16'h0;
      cfg_r <= lbus_pkg::CFG_RST;
    end else begin
      if (ctrl_wr) begin
        cyc_r <= hwdata[2:0];
        byte_r <= hwdata[lbus_pkg::CTRL_BYTE_BIT];
        first_r <= hwdata[lbus_pkg::CTRL_FIRST_BIT];
      end
      if (addr_wr)
        addr_r <= hwdata[19:0];
      if (wdata_wr)
        wdata_r <= hwdata[15:0];
      if (cfg_wr)
        cfg_r <= hwdata[3:0];
    end
  end

  // Pin synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {ready_m, ready_s, hold_m, hold_s} <= 4'h0;
      ad_m <= 16'h0;
      ad_s <= 16'h0;
    end else begin
      ready_m <= ready_i;
      ready_s <= ready_m;
      hold_m <= hold_ack_i;
      hold_s <= hold_m;
      ad_m <= addr_data_lines_i;
      ad_s <= ad_m;
    end
  end

  // One bus state lasts TDIV clocks
  wire tick = (cnt_r == ($clog2(TDIV))'(TDIV - 1));
  wire is_mem = (cyc_r == lbus_pkg::CYC_MEM_RD) || (cyc_r == lbus_pkg::CYC_MEM_WR);
  wire is_rd = (cyc_r == lbus_pkg::CYC_MEM_RD) || (cyc_r == lbus_pkg::CYC_IO_RD);
  wire is_wr = (cyc_r == lbus_pkg::CYC_MEM_WR) || (cyc_r == lbus_pkg::CYC_IO_WR);
  wire is_inta = (cyc_r == lbus_pkg::CYC_INTA);
  wire in_address = (state_r == lbus_pkg::ST_ADDRESS);
  wire in_t2 = (state_r == lbus_pkg::ST_T2);
  wire in_wait = (state_r == lbus_pkg::ST_T3) || (state_r == lbus_pkg::ST_WAIT);
  wire in_data = in_t2 || in_wait || (state_r == lbus_pkg::ST_T4);
  wire finish = tick && in_wait && ready_s;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      lbus_pkg::ST_IDLE: if (pend_r) state_nxt = lbus_pkg::ST_ADDRESS;
      lbus_pkg::ST_ADDRESS: state_nxt = lbus_pkg::ST_T2;
      lbus_pkg::ST_T2: state_nxt = lbus_pkg::ST_T3;
      // wait for ready
      // Hold does not stop a cycle in flight, it only floats the pins
      lbus_pkg::ST_T3, lbus_pkg::ST_WAIT: state_nxt = ready_s ? lbus_pkg::ST_T4 : lbus_pkg::ST_WAIT;
      lbus_pkg::ST_T4: state_nxt = lbus_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= lbus_pkg::ST_IDLE;
      cnt_r <= '0;
      pend_r <= 1'b0;
      rdata_r <= 16'h0;
    end else begin
      cnt_r <= tick ? '0 : cnt_r + 1'b1;
      if (tick)
        state_r <= state_nxt;
      if (ctrl_wr)
        pend_r <= 1'b1;
      else if (tick && state_r == lbus_pkg::ST_IDLE)
        pend_r <= 1'b0;
      if (finish && is_rd)
        rdata_r <= ad_s;
    end
  end

  // Pin values, registered one clock after the state they belong to
  // A word at an odd address is not split: it goes out as a word
  wire low_address_bit = byte_r && addr_r[0];
  wire hbe_n_addr = first_r ? 1'b0 : (byte_r && !addr_r[0]);
  wire ad_oe_nxt = !hold_s && !is_inta && (in_address || (is_wr && in_data));
  wire [15:0] ad_nxt = in_address ? {addr_r[15:1], low_address_bit} : wdata_r;
  wire [3:0] uas_nxt = in_address ? (is_mem ? addr_r[19:16] : 4'h0) :
                       in_data ? {1'b0, irq_q_r, cfg_r[1:0]} : 4'h0;
  wire hbe_nxt = in_address ? hbe_n_addr : in_data ? cfg_r[lbus_pkg::CFG_SEVEN_BIT] : 1'b1;
  // first clock of T2 left high
  wire rd_nxt = !(is_rd && ((in_t2 && cnt_r != '0) || in_wait));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q_r <= 1'b0;
      addr_data_lines_o <= 16'h0;
      addr_data_lines_oe <= 1'b0;
      upper_addr_status_o <= 4'h0;
      upper_addr_status_oe <= 1'b0;
      high_byte_enable_n_o <= 1'b1;
      high_byte_enable_oe <= 1'b0;
      read_n_o <= 1'b1;
      read_n_oe <= 1'b0;
      second_status_pin_o <= 1'b0;
    end else begin
      irq_q_r <= cfg_r[lbus_pkg::CFG_IRQ_BIT];
      addr_data_lines_o <= ad_nxt;
      addr_data_lines_oe <= ad_oe_nxt;
      upper_addr_status_o <= uas_nxt;
      high_byte_enable_n_o <= hbe_nxt;
      read_n_o <= rd_nxt;
      upper_addr_status_oe <= !hold_s;
      high_byte_enable_oe <= !hold_s;
      read_n_oe <= !hold_s;
      second_status_pin_o <= is_mem;
    end
  end

  // Address and data state checks on pin values apply only while no hold floats them
  sequence addr_live;
    in_address && !hold_s;
  endsequence
  sequence data_live;
    in_data && !hold_s;
  endsequence

  rd_after_float_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(read_n_o) |-> !addr_data_lines_oe && $past(!addr_data_lines_oe))
    else $error("read strobe fell while lines driven");
  hold_float_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hold_s |=> !addr_data_lines_oe && !upper_addr_status_oe && !high_byte_enable_oe && !read_n_oe)
    else $error("pin driven during hold");
  // Checks the address-to-T2 and T2-to-T3 hand-overs at their tick, so it holds for any TDIV
  state_order_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick && (in_address || in_t2)) |=> state_r == ($past(in_address) ? lbus_pkg::ST_T2 : lbus_pkg::ST_T3))
    else $error("bus states out of order");
  wait_state_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (in_wait && tick && !ready_s) |=> state_r == lbus_pkg::ST_WAIT)
    else $error("no wait state without ready");
  io_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_live and !is_mem) |=> upper_addr_status_o == 4'h0)
    else $error("upper lines not low in I/O address");
  mem_addr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_live and is_mem) |=> upper_addr_status_o == $past(addr_r[19:16]))
    else $error("upper address bits wrong");
  status_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
    data_live |=> !upper_addr_status_o[3] && upper_addr_status_o[1:0] == $past(cfg_r[1:0])
      && upper_addr_status_o[2] == $past(cfg_r[lbus_pkg::CFG_IRQ_BIT], 2))
    else $error("status lines wrong");
  seven_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
    data_live |=> high_byte_enable_n_o == $past(cfg_r[lbus_pkg::CFG_SEVEN_BIT]))
    else $error("status seven wrong");
  read_span_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (in_wait && is_rd && !hold_s) |=> !read_n_o)
    else $error("read strobe high in wait");
  size_sel_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_live and !is_inta) |=> addr_data_lines_oe && addr_data_lines_o[0] == $past(low_address_bit)
      && high_byte_enable_n_o == $past(hbe_n_addr))
    else $error("size select wrong in address state");

  // Ownership of the shared lines, then high byte enable and read strobe levels
  write_data_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (data_live and is_wr) |=> addr_data_lines_oe && addr_data_lines_o == $past(wdata_r))
    else $error("write data not on shared lines");
  read_float_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (data_live and is_rd) |=> !addr_data_lines_oe)
    else $error("shared lines driven in read data phase");
  inta_float_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (is_inta && state_r != lbus_pkg::ST_IDLE) |=> !addr_data_lines_oe)
    else $error("shared lines driven in acknowledge");
  first_ack_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (in_address && first_r) |=> !high_byte_enable_n_o)
    else $error("high byte enable high in first acknowledge");
  strobe_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!in_t2 && !in_wait) |=> read_n_o)
    else $error("read strobe low outside read states");
  idle_none_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == lbus_pkg::ST_IDLE) |=> high_byte_enable_n_o)
    else $error("high byte enable low while idle");
endmodule

// ---- bench/lbus_partner.sv ----
/*
  Memory or I/O device on the local bus: snoops the shared lines, returns
  read data while the read strobe is low, and holds ready low when slow.
  Assumes the bench resolves the shared lines from the enables.
*/
`timescale 1ns/1ps
module lbus_partner (
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset, active low
  input wire logic [15:0] wire_ad, // resolved shared lines
  input wire logic dev_drives, // engine drives the shared lines
  input wire logic read_n, // read strobe, pulled up when floating
  input wire logic go, // arm the stall count
  input wire logic [7:0] stall, // clocks of not ready
  output logic [15:0] drive_d, // our value on the shared lines
  output logic ready // transfer acknowledge
);
  logic [15:0] latch_r;
  logic [7:0] cnt_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_r <= 16'h0;
      cnt_r <= 8'h0;
      drive_d <= 16'h0;
    end else begin
      if (dev_drives) latch_r <= wire_ad;
      cnt_r <= go ? stall : ((cnt_r != 8'h0) ? cnt_r - 8'h1 : 8'h0);
      // Released lines keep toggling so no stale value looks valid
      drive_d <= !read_n ? (latch_r ^ 16'hc3c3) : ~drive_d;
    end
  end
  assign ready = (cnt_r == 8'h0);
endmodule

// ---- bench/tb_top.sv ----
/*
  Self-checking bench for the local bus cycle engine: AHB-Lite register
  tasks, a pin monitor and directed bus cycles of every kind.
  Assumes lbus_partner answers on the far side.
*/
`timescale 1ns/1ps
module tb_top;
  localparam int TD = 4;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hold_ack_i = 1'b0, go = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, ad_oe, up_oe, hbe_oe, rdn_oe, rdn, hbe_n, ssp, ready, rd_seen, clash, saw_tw;
  logic [15:0] ad_o, part_d;
  logic [3:0] up;
  logic [7:0] stall = 8'h0;
  logic [21:0] exp_ad, msk_ad, exp_st, msk_st, p1, p2;
  int ad_run, ad_max, st_run, st_max, errors = 0, num_checks = 0, cyc = 0;
  always #25 hclk = ~hclk;
  lbus_engine #(.TDIV(TD)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .addr_data_lines_i(ad_oe ? ad_o : part_d), .addr_data_lines_o(ad_o),
    .addr_data_lines_oe(ad_oe), .upper_addr_status_o(up), .upper_addr_status_oe(up_oe),
    .high_byte_enable_n_o(hbe_n), .high_byte_enable_oe(hbe_oe), .read_n_o(rdn), .read_n_oe(rdn_oe),
    .second_status_pin_o(ssp), .ready_i(ready), .hold_ack_i(hold_ack_i));
  lbus_partner part (.hclk(hclk), .hresetn(hresetn), .wire_ad(ad_oe ? ad_o : part_d), .dev_drives(ad_oe),
    .read_n(rdn_oe ? rdn : 1'b1), .go(go), .stall(stall), .drive_d(part_d), .ready(ready));
  task automatic results;
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Starts a cycle and polls the state until busy clears
  task automatic run(input logic [4:0] ctl, input logic [7:0] wt);
    logic [31:0] s;
    int n;
    {rd_seen, clash, saw_tw} = 3'h0;
    ad_max = 0;
    st_max = 0;
    stall <= wt;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    ahb(lbus_pkg::CTRL_OFF, 1'b1, {27'h0, ctl}, s);
    n = 0;
    do begin
      ahb(lbus_pkg::STAT_OFF, 1'b0, 32'h0, s);
      if (s[2:0] === 3'h4) saw_tw = 1'b1;
      n++;
    end while (s[lbus_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 200);
    chk(s[lbus_pkg::STAT_BUSY_BIT], 1'b0);
  endtask
  // Longest runs of the expected address and status tuples
  always @(negedge hclk) begin
    p1 = {up, ad_o, hbe_n, ad_oe};
    p2 = {up, hbe_n, ssp, ad_o};
    ad_run = (((p1 ^ exp_ad) & msk_ad) === 22'h0) ? ad_run + 1 : 0;
    st_run = (((p2 ^ exp_st) & msk_st) === 22'h0) ? st_run + 1 : 0;
    if (ad_run > ad_max) ad_max = ad_run;
    if (st_run > st_max) st_max = st_run;
    if (rdn_oe && rdn === 1'b0) rd_seen = 1'b1;
    if (rdn_oe && rdn === 1'b0 && ad_oe) clash = 1'b1;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end
  initial begin
    logic [31:0] r;
    logic [19:0] a;
    logic [15:0] ln;
    logic [2:0] k;
    logic mem, rdc, byt, hb;
    logic [2:0] kinds [4];
    logic [19:0] addrs [4];
    kinds = '{lbus_pkg::CYC_MEM_RD, lbus_pkg::CYC_IO_WR, lbus_pkg::CYC_MEM_WR, lbus_pkg::CYC_IO_RD};
    addrs = '{20'h51234, 20'h00033, 20'habc42, 20'h00f80};
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(lbus_pkg::CFG_OFF, 1'b0, 32'h0, r);
    chk(r, {28'h0, lbus_pkg::CFG_RST});
    ahb(lbus_pkg::STAT_OFF, 1'b0, 32'h0, r);
    chk(r, 32'h0);
    ahb(8'h20, 1'b0, 32'h0, r);
    chk(r, 32'h0);
    for (int i = 0; i < 4; i++) begin
      k = kinds[i];
      a = addrs[i];
      byt = i[0] ^ i[1];
      mem = (k == lbus_pkg::CYC_MEM_RD) || (k == lbus_pkg::CYC_MEM_WR);
      rdc = (k == lbus_pkg::CYC_MEM_RD) || (k == lbus_pkg::CYC_IO_RD);
      hb = byt & ~a[0];
      ln = {a[15:1], byt & a[0]};
      ahb(lbus_pkg::CFG_OFF, 1'b1, {28'h0, i[1], i[0], i[1:0]}, r);
      ahb(lbus_pkg::ADDR_OFF, 1'b1, {12'h0, a}, r);
      ahb(lbus_pkg::WDATA_OFF, 1'b1, 32'h9e00 + i, r);
      exp_ad = {mem ? a[19:16] : 4'h0, ln, hb, 1'b1};
      msk_ad = '1;
      exp_st = {1'b0, i[0], i[1:0], i[1], mem, 16'h9e00 ^ {14'h0, i[1:0]}};
      msk_st = rdc ? 22'h3f0000 : '1;
      run({1'b0, byt, k}, (i == 3) ? 8'h1e : 8'h0);
      chk(ad_max >= TD, 32'h1);
      chk(st_max >= 3 * TD, 32'h1);
      chk(rd_seen, rdc);
      chk(clash, 1'b0);
      chk(saw_tw, i == 3);
      if (rdc) begin
        ahb(lbus_pkg::RDATA_OFF, 1'b0, 32'h0, r);
        chk(r, {16'h0, ln ^ 16'hc3c3});
      end
    end
    exp_ad = 22'h0;
    msk_ad = 22'h3;
    run({1'b1, 1'b0, lbus_pkg::CYC_INTA}, 8'h0);
    chk(ad_max >= TD, 32'h1);
    chk(rd_seen, 1'b0);
    hold_ack_i <= 1'b1;
    repeat (5) @(posedge hclk);
    @(negedge hclk);
    chk({ad_oe, up_oe, hbe_oe, rdn_oe}, 4'h0);
    ahb(lbus_pkg::CTRL_OFF, 1'b1, {29'h0, lbus_pkg::CYC_MEM_RD}, r);
    ahb(lbus_pkg::STAT_OFF, 1'b0, 32'h0, r);
    chk(r, 32'h1 << lbus_pkg::STAT_HOLD_BIT);
    hold_ack_i <= 1'b0;
    repeat (5) @(posedge hclk);
    @(negedge hclk);
    // Idle engine leaves the shared lines released, the other pins driven
    chk({ad_oe, up_oe, hbe_oe, rdn_oe, hresp}, 5'h0e);
    results();
  end
endmodule
